// ==== optw_decode.sv ====
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "optw_map.svh"
module optw_decode (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic i_clk_en,
   input wire optw_pkg::reg_req_t i_bus,
   input wire logic i_stack_overflow,
   input wire logic i_stack_underflow,
   input wire logic i_serial_program_clock_pin,
   input wire logic i_serial_program_data_pin,
   input wire logic i_master_clear_program_voltage_pin,
   output logic [15:0] o_rdata,
   output logic o_pins_gpio,
   output logic o_bor_sel_1v9,
   output logic o_stack_reset,
   output logic o_cap_on_port_f_bit_zero_pin,
   output logic o_low_voltage_program_enable,
   output logic o_clock_multiplier_enable,
   output logic [1:0] o_self_write_protect
);
   import optw_pkg::*;

   optw_state_t st_r;
   optw_state_t st_nxt;
   logic [2:0] pin_levels;
   logic stack_fault;
   logic wr_word;
   logic wr_stat;
   logic rd_word;
   logic rd_stat;
   // reset state decodes the erased word, so outputs never disagree with it after reset
   localparam logic [13:0] erased_word = `OPTW_RESET;

   // unimplemented positions always hold ones, both when stored and when read
   function automatic logic [13:0] fill_unimpl(input logic [13:0] w);
      fill_unimpl = w | ~`OPTW_IMPL_MASK;
   endfunction

   function automatic logic addr_hit(input reg_req_t b, input logic [7:0] a);
      addr_hit = (b.addr == a);
   endfunction

   optw_pin_sync u_pin_sync (
      .i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n),
      .i_clk_en(i_clk_en),
      .i_pins({i_master_clear_program_voltage_pin, i_serial_program_data_pin, i_serial_program_clock_pin}),
      .o_levels(pin_levels)
   );

   assign stack_fault = i_stack_overflow | i_stack_underflow;
   assign wr_word = i_bus.wr & addr_hit(i_bus, `OPTW_ADDR_WORD);
   assign wr_stat = i_bus.wr & addr_hit(i_bus, `OPTW_ADDR_STAT);
   assign rd_word = i_bus.rd & addr_hit(i_bus, `OPTW_ADDR_WORD);
   assign rd_stat = i_bus.rd & addr_hit(i_bus, `OPTW_ADDR_STAT);

   always_comb begin
      st_nxt = st_r;

      // the programmer is the only writer; nothing in the core changes the word
      if (wr_word) begin
         st_nxt.word = fill_unimpl(i_bus.wdata[13:0]);
      end

      // decoded controls follow the word being taken, so they never lag a write
      st_nxt.pins_gpio = st_nxt.word[`OPTW_BIT_DEBUG]; // RULE1
      st_nxt.bor_sel_1v9 = st_nxt.word[`OPTW_BIT_BOR_SEL]; // RULE3
      st_nxt.cap_on_port_f = ~st_nxt.word[`OPTW_BIT_CAP]; // RULE7
      st_nxt.low_voltage_program_enable = st_nxt.word[`OPTW_BIT_LOW_VOLT_PROG];
      st_nxt.clock_multiplier_enable = st_nxt.word[`OPTW_BIT_CLKMUL];
      st_nxt.self_write_protect = {st_nxt.word[`OPTW_BIT_WRT_HI], st_nxt.word[`OPTW_BIT_WRT_LO]};

      // reset request only while enabled; a disabled fault is just logged
      st_nxt.stack_reset = stack_fault & st_r.word[`OPTW_BIT_STKRST]; // RULE4 RULE5

      // sticky log; a fault in the clearing cycle wins
      if (wr_stat && i_bus.wdata[`OPTW_ST_FAULT]) begin
         st_nxt.stack_fault_seen = 1'b0;
      end
      if (stack_fault) begin
         st_nxt.stack_fault_seen = 1'b1;
      end

      // read data live for one cycle only; unmapped reads return zero
      st_nxt.rdata = 16'h0000;
      case (1'b1)
         rd_word: begin
            st_nxt.rdata = {2'h0, fill_unimpl(st_r.word)}; // RULE2
         end
         rd_stat: begin
            st_nxt.rdata[`OPTW_ST_FAULT] = st_r.stack_fault_seen;
            st_nxt.rdata[`OPTW_ST_DEBUG_OWNS] = ~st_r.pins_gpio;
            st_nxt.rdata[`OPTW_ST_BOR_1V9] = st_r.bor_sel_1v9;
            // pin levels only mean anything while the pins are ordinary I/O
            st_nxt.rdata[`OPTW_ST_PIN_CLK] = pin_levels[0] & st_r.pins_gpio;
            st_nxt.rdata[`OPTW_ST_PIN_DAT] = pin_levels[1] & st_r.pins_gpio;
            st_nxt.rdata[`OPTW_ST_STKRST] = st_r.stack_reset;
         end
         default: begin
            st_nxt.rdata = 16'h0000;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         // erased word: every option bit at its ones value
         st_r.word <= erased_word;
         st_r.rdata <= '0;
         st_r.stack_fault_seen <= 1'b0;
         st_r.stack_reset <= 1'b0;
         st_r.pins_gpio <= erased_word[`OPTW_BIT_DEBUG];
         st_r.bor_sel_1v9 <= erased_word[`OPTW_BIT_BOR_SEL];
         st_r.cap_on_port_f <= ~erased_word[`OPTW_BIT_CAP];
         st_r.low_voltage_program_enable <= erased_word[`OPTW_BIT_LOW_VOLT_PROG];
         st_r.clock_multiplier_enable <= erased_word[`OPTW_BIT_CLKMUL];
         st_r.self_write_protect <= {erased_word[`OPTW_BIT_WRT_HI], erased_word[`OPTW_BIT_WRT_LO]};
      end else if (i_clk_en) begin
         st_r <= st_nxt;
      end
   end

   assign o_rdata = st_r.rdata;
   assign o_pins_gpio = st_r.pins_gpio;
   assign o_bor_sel_1v9 = st_r.bor_sel_1v9;
   assign o_stack_reset = st_r.stack_reset;
   assign o_cap_on_port_f_bit_zero_pin = st_r.cap_on_port_f;
   assign o_low_voltage_program_enable = st_r.low_voltage_program_enable;
   assign o_clock_multiplier_enable = st_r.clock_multiplier_enable;
   assign o_self_write_protect = st_r.self_write_protect;

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_reset_n);

   // the pin owner must always match the stored debug bit
   property p_pins_follow_debug;
      o_pins_gpio == st_r.word[`OPTW_BIT_DEBUG];
   endproperty
   a_pins_follow_debug: assert property (p_pins_follow_debug) // RULE1
      else $error("pin ownership disagrees with debug bit");

   // a written debug bit shows on the pin owner one cycle later
   property p_debug_write_lands;
      (i_clk_en && wr_word) |=> (o_pins_gpio == $past(i_bus.wdata[`OPTW_BIT_DEBUG]));
   endproperty
   a_debug_write_lands: assert property (p_debug_write_lands) // RULE1
      else $error("debug bit write did not reach pin ownership");

   property p_unimpl_reads_one;
      (i_clk_en && rd_word) |=> (o_rdata[`OPTW_BIT_UNIMP11] && o_rdata[15:14] == 2'h0);
   endproperty
   a_unimpl_reads_one: assert property (p_unimpl_reads_one) // RULE2
      else $error("unimplemented bit 11 did not read as one");

   property p_bor_select;
      (i_clk_en && wr_word) |=> (o_bor_sel_1v9 == $past(i_bus.wdata[`OPTW_BIT_BOR_SEL]));
   endproperty
   a_bor_select: assert property (p_bor_select) // RULE3
      else $error("brown-out threshold select does not follow the word");

   property p_stack_reset_on;
      (i_clk_en && stack_fault && st_r.word[`OPTW_BIT_STKRST]) |=> o_stack_reset;
   endproperty
   a_stack_reset_on: assert property (p_stack_reset_on) // RULE4
      else $error("enabled stack fault gave no reset");

   property p_stack_reset_off;
      (i_clk_en && !st_r.word[`OPTW_BIT_STKRST]) |=> !o_stack_reset;
   endproperty
   a_stack_reset_off: assert property (p_stack_reset_off) // RULE5
      else $error("reset raised while stack fault reset disabled");

   property p_cap_routing;
      o_cap_on_port_f_bit_zero_pin == !st_r.word[`OPTW_BIT_CAP];
   endproperty
   a_cap_routing: assert property (p_cap_routing) // RULE7
      else $error("capacitor routing disagrees with enable bit");

   property p_fault_sticky;
      (i_clk_en && stack_fault) |=> st_r.stack_fault_seen;
   endproperty
   a_fault_sticky: assert property (p_fault_sticky) // RULE4
      else $error("stack fault not logged");

   // every remaining word field reaches its output one cycle after a write
   property p_low_volt_prog_lands;
      (i_clk_en && wr_word) |=> (o_low_voltage_program_enable == $past(i_bus.wdata[`OPTW_BIT_LOW_VOLT_PROG]));
   endproperty
   a_low_volt_prog_lands: assert property (p_low_volt_prog_lands)
      else $error("low-voltage programming enable does not follow the word");

   property p_clock_mul_lands;
      (i_clk_en && wr_word) |=> (o_clock_multiplier_enable == $past(i_bus.wdata[`OPTW_BIT_CLKMUL]));
   endproperty
   a_clock_mul_lands: assert property (p_clock_mul_lands)
      else $error("clock multiplier enable does not follow the word");

   property p_write_protect_lands;
      (i_clk_en && wr_word) |=> (o_self_write_protect[1] == $past(i_bus.wdata[`OPTW_BIT_WRT_HI])
         && o_self_write_protect[0] == $past(i_bus.wdata[`OPTW_BIT_WRT_LO]));
   endproperty
   a_write_protect_lands: assert property (p_write_protect_lands)
      else $error("self-write protection does not follow the word");

   property p_cap_write_lands;
      (i_clk_en && wr_word) |=> (o_cap_on_port_f_bit_zero_pin == !$past(i_bus.wdata[`OPTW_BIT_CAP]));
   endproperty
   a_cap_write_lands: assert property (p_cap_write_lands) // RULE7
      else $error("capacitor routing write did not land");

   property p_bor_follows_word;
      o_bor_sel_1v9 == st_r.word[`OPTW_BIT_BOR_SEL];
   endproperty
   a_bor_follows_word: assert property (p_bor_follows_word) // RULE3
      else $error("brown-out threshold select disagrees with stored word");

   // no write path may ever clear an unimplemented position
   property p_unimpl_stored_ones;
      (st_r.word & ~`OPTW_IMPL_MASK) == ~`OPTW_IMPL_MASK;
   endproperty
   a_unimpl_stored_ones: assert property (p_unimpl_stored_ones) // RULE2
      else $error("unimplemented position stored as zero");

   property p_word_read_value;
      (i_clk_en && rd_word) |=> (o_rdata[13:0] == $past(st_r.word));
   endproperty
   a_word_read_value: assert property (p_word_read_value) // RULE2
      else $error("option word read returned the wrong value");

   // read data stand for one cycle only, and unmapped reads give zero
   property p_rdata_idle;
      (i_clk_en && !rd_word && !rd_stat) |=> (o_rdata == 16'h0000);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data present without a mapped read");

   property p_stat_debug_owns;
      (i_clk_en && rd_stat) |=> (o_rdata[`OPTW_ST_DEBUG_OWNS] == !$past(o_pins_gpio));
   endproperty
   a_stat_debug_owns: assert property (p_stat_debug_owns) // RULE1
      else $error("status pin ownership disagrees with the debug bit");

   // pins given to debug must not leak their levels into status
   property p_stat_pins_hidden;
      (i_clk_en && rd_stat && !o_pins_gpio) |=> (!o_rdata[`OPTW_ST_PIN_CLK] && !o_rdata[`OPTW_ST_PIN_DAT]);
   endproperty
   a_stat_pins_hidden: assert property (p_stat_pins_hidden) // RULE1
      else $error("debug-owned pin level visible in status");

   property p_stat_bor;
      (i_clk_en && rd_stat) |=> (o_rdata[`OPTW_ST_BOR_1V9] == $past(o_bor_sel_1v9));
   endproperty
   a_stat_bor: assert property (p_stat_bor) // RULE3
      else $error("status threshold bit disagrees with the select");

   property p_stat_stack_reset;
      (i_clk_en && rd_stat) |=> (o_rdata[`OPTW_ST_STKRST] == $past(o_stack_reset));
   endproperty
   a_stat_stack_reset: assert property (p_stat_stack_reset) // RULE4
      else $error("status reset bit disagrees with the reset request");

   // the request is a pulse per fault cycle, never a latched level
   property p_stack_reset_drops;
      (i_clk_en && !stack_fault) |=> !o_stack_reset;
   endproperty
   a_stack_reset_drops: assert property (p_stack_reset_drops) // RULE5
      else $error("reset request outlived the stack fault");

   // a reset request always traces back to an enabled fault
   property p_stack_reset_cause;
      (o_stack_reset && $past(i_clk_en)) |-> ($past(stack_fault) && $past(st_r.word[`OPTW_BIT_STKRST]));
   endproperty
   a_stack_reset_cause: assert property (p_stack_reset_cause) // RULE5
      else $error("reset request without an enabled stack fault");

   property p_fault_clears;
      (i_clk_en && wr_stat && i_bus.wdata[`OPTW_ST_FAULT] && !stack_fault) |=> !st_r.stack_fault_seen;
   endproperty
   a_fault_clears: assert property (p_fault_clears)
      else $error("stack fault log did not clear");

   // the log only falls on a status write
   property p_fault_holds;
      (i_clk_en && st_r.stack_fault_seen && !wr_stat) |=> st_r.stack_fault_seen;
   endproperty
   a_fault_holds: assert property (p_fault_holds)
      else $error("stack fault log lost without a clearing write");

   property p_freeze;
      !i_clk_en |=> $stable(st_r);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("state moved while the clock enable was low");

   property p_word_only_by_write;
      !wr_word |=> $stable(st_r.word);
   endproperty
   a_word_only_by_write: assert property (p_word_only_by_write)
      else $error("option word changed without a word write");
endmodule
`default_nettype wire

// ==== optw_map.svh ====
`ifndef OPTW_MAP_SVH
`define OPTW_MAP_SVH
// Behaviour
// RULE1: a debug-mode bit of 1 leaves the serial programming clock and data pins as general purpose I/O, 0 gives them to debug.
// RULE2: option word bit 11 is not implemented and always reads as 1.
// RULE3: the brown-out select bit picks 1.9V when 1 and 2.5V when 0.
// RULE4: with the stack fault reset enable bit at 1, a stack overflow or underflow requests a device reset.
// RULE5: with the stack fault reset enable bit at 0, a stack overflow or underflow causes no reset by itself.
// RULE6: the external programmer keeps the debug-mode bit at 1 for normal operation.
// RULE7: a regulator capacitor enable bit of 0 routes the capacitor function onto port F bit zero.

// register addresses
`define OPTW_ADDR_WORD 8'h00
`define OPTW_ADDR_STAT 8'h01

// option word layout
`define OPTW_BIT_LOW_VOLT_PROG 13
`define OPTW_BIT_DEBUG 12
`define OPTW_BIT_UNIMP11 11
`define OPTW_BIT_BOR_SEL 10
`define OPTW_BIT_STKRST 9
`define OPTW_BIT_CLKMUL 8
`define OPTW_BIT_CAP 4
`define OPTW_BIT_WRT_HI 1
`define OPTW_BIT_WRT_LO 0
`define OPTW_IMPL_MASK 14'h3713
`define OPTW_RESET 14'h3fff

// status layout
`define OPTW_ST_FAULT 0
`define OPTW_ST_DEBUG_OWNS 1
`define OPTW_ST_BOR_1V9 2
`define OPTW_ST_PIN_CLK 3
`define OPTW_ST_PIN_DAT 4
`define OPTW_ST_STKRST 5

`endif

// ==== optw_pkg.sv ====
package optw_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic [2:0] ff1;
      logic [2:0] ff2;
      logic [2:0] ff3;
      logic [2:0] level;
   } sync_state_t;

   typedef struct packed {
      logic [13:0] word;
      logic [15:0] rdata;
      logic stack_fault_seen;
      logic stack_reset;
      logic pins_gpio;
      logic bor_sel_1v9;
      logic cap_on_port_f;
      logic low_voltage_program_enable;
      logic clock_multiplier_enable;
      logic [1:0] self_write_protect;
   } optw_state_t;
endpackage

// ==== optw_pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module optw_pin_sync (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic i_clk_en,
   input wire logic [2:0] i_pins,
   output logic [2:0] o_levels
);
   import optw_pkg::*;

   sync_state_t st_r;
   sync_state_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.ff1 = i_pins;
      st_nxt.ff2 = st_r.ff1;
      st_nxt.ff3 = st_r.ff2;
      // accept a change only once two stages agree, so a single late sample cannot glitch through
      for (int i = 0; i < 3; i++) begin
         if (st_r.ff2[i] == st_r.ff3[i]) begin
            st_nxt.level[i] = st_r.ff3[i];
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_r <= '0;
      end else if (i_clk_en) begin
         st_r <= st_nxt;
      end
   end

   assign o_levels = st_r.level;
endmodule
`default_nettype wire

// ==== optw_prog_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module optw_prog_model (
   input wire logic i_clk_sys,
   input wire logic [15:0] i_rdata,
   output var optw_pkg::reg_req_t o_bus
);
   import optw_pkg::*;
   // erased word, debug bit left at 1 for normal use
   localparam logic [13:0] normal_word = 14'h3fff;
   initial o_bus = '0;
   // released lines show the inverse, so a stale value cannot pass for a live one
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_clk_sys);
      o_bus <= {a, d, 1'b1, 1'b0};
      @(posedge i_clk_sys);
      o_bus <= {~a, ~d, 2'b00};
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] q);
      @(posedge i_clk_sys);
      o_bus <= {a, 16'h0000, 1'b0, 1'b1};
      @(posedge i_clk_sys);
      o_bus <= {~a, 16'hffff, 2'b00};
      #1 q = i_rdata;
   endtask
   task automatic program_normal;
      wr(8'h00, {2'b00, normal_word});
   endtask
endmodule
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import optw_pkg::*;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic ovf = 1'b0;
   logic unf = 1'b0;
   logic pclk = 1'b0;
   logic pdat = 1'b0;
   logic clk_en = 1'b1;
   reg_req_t bus;
   logic [15:0] rdata;
   logic [15:0] q;
   logic gpio, bor, stk, cap, lv_prog, mul;
   logic [1:0] wp;
   int mismatches = 0;
   int num_checks = 0;
   int resets = 0;
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (stk === 1'b1) resets++;
   optw_decode u_optw_decode (.i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_clk_en(clk_en), .i_bus(bus),
      .i_stack_overflow(ovf), .i_stack_underflow(unf), .i_serial_program_clock_pin(pclk),
      .i_serial_program_data_pin(pdat), .i_master_clear_program_voltage_pin(1'b0), .o_rdata(rdata),
      .o_pins_gpio(gpio), .o_bor_sel_1v9(bor), .o_stack_reset(stk), .o_cap_on_port_f_bit_zero_pin(cap),
      .o_low_voltage_program_enable(lv_prog), .o_clock_multiplier_enable(mul), .o_self_write_protect(wp));
   optw_prog_model u_optw_prog_model (.i_clk_sys(clk_sys), .i_rdata(rdata), .o_bus(bus));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // decoded outputs packed as {gpio, bor, cap, lv_prog, mul, wp}
   task automatic outs(input logic [15:0] exp);
      repeat (2) @(posedge clk_sys);
      #1 chk({9'h000, gpio, bor, cap, lv_prog, mul, wp}, exp);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
      u_optw_prog_model.rd(a, q);
      chk(q, exp);
   endtask
   // one fault cycle, then count reset pulses over a short window
   task automatic fault(input logic over, input int exp);
      resets = 0;
      @(posedge clk_sys);
      ovf <= over;
      unf <= ~over;
      @(posedge clk_sys);
      ovf <= 1'b0;
      unf <= 1'b0;
      repeat (4) @(posedge clk_sys);
      #1 chk(16'(resets), 16'(exp));
   endtask
   task automatic finish_test;
      $display("checks %0d, mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      #20us;
      mismatches++;
      finish_test();
   end
   initial begin
      repeat (8) @(posedge clk_sys);
      reset_n <= 1'b1;
      outs(16'h006f);
      rdchk(8'h00, 16'h3fff);
      rdchk(8'h05, 16'h0000);
      u_optw_prog_model.wr(8'h00, 16'h2fff);
      outs(16'h002f);
      rdchk(8'h00, 16'h2fff);
      rdchk(8'h01, 16'h0006);
      u_optw_prog_model.wr(8'h00, 16'h0000);
      outs(16'h0010);
      rdchk(8'h00, 16'h08ec);
      fault(1'b1, 0);
      fault(1'b0, 0);
      rdchk(8'h01, 16'h0003);
      u_optw_prog_model.wr(8'h01, 16'h0001);
      rdchk(8'h01, 16'h0002);
      u_optw_prog_model.program_normal();
      outs(16'h006f);
      fault(1'b1, 1);
      fault(1'b0, 1);
      @(posedge clk_sys);
      pclk <= 1'b1;
      repeat (6) @(posedge clk_sys);
      rdchk(8'h01, 16'h000d);
      @(posedge clk_sys);
      pclk <= 1'b0;
      pdat <= 1'b1;
      repeat (6) @(posedge clk_sys);
      rdchk(8'h01, 16'h0015);
      // a word write while the clock enable is low must be lost
      u_optw_prog_model.wr(8'h00, 16'h0000);
      @(posedge clk_sys);
      clk_en <= 1'b0;
      u_optw_prog_model.wr(8'h00, 16'h3fff);
      @(posedge clk_sys);
      clk_en <= 1'b1;
      outs(16'h0010);
      // mid-run reset brings back the erased word and an empty log
      @(posedge clk_sys);
      reset_n <= 1'b0;
      pdat <= 1'b0;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      outs(16'h006f);
      rdchk(8'h00, 16'h3fff);
      rdchk(8'h01, 16'h0004);
      finish_test();
   end
endmodule
`default_nettype wire
